// ===== hdl/iom_monitor.sv
// live i/o monitor, fault alarms, hour meter and alarm history
`timescale 1ns/1ps

module iom_monitor
	import iom_pkg::*;
#(
	parameter longint SILENCE_CYC = IOM_SILENCE_CYC,
	parameter longint HOUR_CYC = IOM_HOUR_CYC
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire iom_live_t live_pins,
	input wire logic supervisor_msg,
	input wire logic coil_short_sense,
	input wire logic high_side_cmd,
	input wire logic high_side_sense,
	input wire logic [2:0] group_short_sense,
	input wire logic mem_fault_sense,
	input wire logic key_on,
	input wire logic hour_mode_key_on,
	input wire logic [IOM_TEMP_W-1:0] temperature,
	input wire logic parameter_backup_request,
	input wire logic parameter_reload_request,
	input wire logic [IOM_IDX_W-1:0] log_rd_idx,
	output iom_live_t live,
	output iom_faults_t faults,
	output logic operation_inhibit,
	output logic load_defaults,
	output logic backup_ack,
	output logic [IOM_HOUR_W-1:0] hour_meter,
	output iom_entry_t log_rd_data,
	output logic [IOM_IDX_W-1:0] log_fill
);

	// =====================================================================
	// pin synchronisers
	iom_live_t live_s1; // first stage, read only by second
	iom_live_t live_s2;
	logic [9:0] raw_s1; // fault senses and strobes, first stage
	logic [9:0] raw_s2;
	logic [9:0] raw_in;
	assign raw_in = {supervisor_msg, coil_short_sense, high_side_cmd,
		high_side_sense, group_short_sense, mem_fault_sense, key_on,
		parameter_backup_request};
	// two flops on the live pins, fault senses, key and backup request before logic
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			live_s1 <= '0;
			live_s2 <= '0;
			raw_s1 <= '0;
			raw_s2 <= '0;
		end else if (ce) begin
			live_s1 <= live_pins;
			live_s2 <= live_s1;
			raw_s1 <= raw_in;
			raw_s2 <= raw_s1;
		end
	end
	logic msg_s, coil_s, hs_cmd_s, hs_sense_s, mem_s, key_s, backup_s;
	logic [2:0] grp_s;
	assign {msg_s, coil_s, hs_cmd_s, hs_sense_s, grp_s, mem_s, key_s,
		backup_s} = raw_s2;

	// =====================================================================
	// live monitor registers; read-only view, fed back only to the hour
	// meter's active test, so console reads cannot steer the device
	iom_live_t next_live;
	always_comb begin
		next_live = live_s2;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			live <= '0;
		end else if (ce) begin
			live <= next_live;
		end
	end

	// =====================================================================
	// fault detection and timers
	logic [31:0] silence_cnt; // cycles since last supervisor message
	logic [31:0] next_silence_cnt;
	logic [42:0] hour_div; // prescaler to one hour
	logic [42:0] next_hour_div;
	logic [IOM_HOUR_W-1:0] next_hour_meter;
	logic key_d; // previous key level for edge detect
	logic next_key_d;
	iom_faults_t next_faults;
	logic next_inhibit, next_load_defaults, next_backup_ack;
	logic backup_d;
	logic next_backup_d;
	logic active; // some valve function is on
	logic [5:0] hw_now; // hardware fault conditions seen this cycle
	assign active = |live.solenoid_valve_output | |live.safety_valves;
	// bits follow the fault record: coil, open, groups, closed
	assign hw_now = {coil_s,
		hs_cmd_s & ~hs_sense_s,
		grp_s[0], grp_s[1], grp_s[2],
		~hs_cmd_s & hs_sense_s};
	always_comb begin
		next_silence_cnt = silence_cnt;
		next_hour_div = hour_div;
		next_hour_meter = hour_meter;
		next_key_d = key_s;
		next_faults = faults;
		next_inhibit = operation_inhibit;
		next_load_defaults = 1'b0;
		next_backup_d = backup_s;
		// backup request only acknowledged; nothing is stored or changed
		next_backup_ack = backup_s & ~backup_d;
		// silence counter; saturates at the timeout
		if (msg_s) begin
			next_silence_cnt = '0;
		end else if (64'(silence_cnt) < SILENCE_CYC) begin
			next_silence_cnt = silence_cnt + 32'h1;
		end
		next_faults.bus_silence_fault =
			(64'(silence_cnt) >= SILENCE_CYC) & ~msg_s;
		// hardware faults stay sticky until the next key cycle
		next_faults[5:0] = faults[5:0] | hw_now;
		// memory fault latches and inhibits operation
		if (mem_s) begin
			next_faults.param_memory_fault = 1'b1;
			next_inhibit = 1'b1;
		end
		// key rising edge: a clean memory reloads defaults, clears latches
		if (key_s && !key_d) begin
			if (!mem_s && faults.param_memory_fault) begin
				next_load_defaults = 1'b1;
				next_faults.param_memory_fault = 1'b0;
				next_inhibit = 1'b0;
			end
			// a fault present on this very edge is kept: set wins
			next_faults[5:0] = hw_now;
		end
		// hour meter runs when powered, or only while a function is active
		if (hour_mode_key_on || active) begin
			if (64'(hour_div) >= HOUR_CYC - 1) begin
				next_hour_div = '0;
				next_hour_meter = hour_meter + 24'h1;
			end else begin
				next_hour_div = hour_div + 43'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			silence_cnt <= '0;
			hour_div <= '0;
			hour_meter <= '0;
			key_d <= 1'b0;
			faults <= '0;
			operation_inhibit <= 1'b0;
			load_defaults <= 1'b0;
			backup_ack <= 1'b0;
			backup_d <= 1'b0;
		end else if (ce) begin
			silence_cnt <= next_silence_cnt;
			hour_div <= next_hour_div;
			hour_meter <= next_hour_meter;
			key_d <= next_key_d;
			faults <= next_faults;
			operation_inhibit <= next_inhibit;
			load_defaults <= next_load_defaults;
			backup_ack <= next_backup_ack;
			backup_d <= next_backup_d;
		end
	end

	// =====================================================================
	// alarm history: newest in slot 0, older shift down
	iom_entry_t shadow [IOM_LOG_DEPTH]; // mirror used to find repeats
	iom_entry_t next_shadow [IOM_LOG_DEPTH];
	logic [IOM_IDX_W-1:0] next_log_fill;
	logic [IOM_NUM_ALARMS-1:0] fault_vec, prev_vec, next_prev_vec, rise;
	logic wr_en;
	logic [IOM_IDX_W-1:0] wr_idx;
	iom_entry_t wr_data;
	logic [IOM_IDX_W-1:0] scan; // slot rewritten into memory this cycle
	logic [IOM_IDX_W-1:0] next_scan;
	assign fault_vec = faults;
	assign rise = fault_vec & ~prev_vec;
	// lowest set bit picks the alarm logged this cycle
	function automatic iom_alarm_t pick(input logic [7:0] v);
		iom_alarm_t c;
		c = IOM_ALM_NONE;
		for (int i = 0; i < IOM_NUM_ALARMS; i++) begin
			if (v[i] && c == IOM_ALM_NONE) begin
				c = iom_alarm_t'(4'(IOM_NUM_ALARMS - i));
			end
		end
		return c;
	endfunction

	always_comb begin
		iom_alarm_t code;
		int hit;
		code = pick(rise);
		hit = -1;
		next_log_fill = log_fill;
		for (int i = 0; i < IOM_LOG_DEPTH; i++) begin
			next_shadow[i] = shadow[i];
		end
		// one alarm logged per cycle; clear its edge only when taken
		next_prev_vec = prev_vec & fault_vec;
		for (int i = 0; i < IOM_NUM_ALARMS; i++) begin
			if (4'(IOM_NUM_ALARMS - i) == code) begin
				next_prev_vec[i] = 1'b1;
			end
		end
		if (code != IOM_ALM_NONE) begin
			for (int i = 0; i < IOM_LOG_DEPTH; i++) begin
				if (i < 32'(log_fill) && shadow[i].code == code && hit < 0) begin
					hit = i;
				end
			end
			if (hit >= 0) begin
				// repeat: bump count, refresh hour and temperature
				if (shadow[hit].count != IOM_CNT_MAX) begin
					next_shadow[hit].count = shadow[hit].count + 8'h1;
				end
				next_shadow[hit].hours = hour_meter;
				next_shadow[hit].temp = temperature;
			end else begin
				// new distinct alarm pushes out the oldest
				for (int i = IOM_LOG_DEPTH - 1; i > 0; i--) begin
					next_shadow[i] = shadow[i-1];
				end
				next_shadow[0] = '{code, 8'h01, hour_meter, temperature};
				if (32'(log_fill) < IOM_LOG_DEPTH) begin
					next_log_fill = log_fill + 3'h1;
				end
			end
		end
		next_scan = (32'(scan) >= IOM_LOG_DEPTH - 1) ? '0 : scan + 3'h1;
		wr_en = 1'b1;
		wr_idx = scan;
		wr_data = shadow[scan];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < IOM_LOG_DEPTH; i++) begin
				shadow[i] <= '0;
			end
			log_fill <= '0;
			prev_vec <= '0;
			scan <= '0;
		end else if (ce) begin
			for (int i = 0; i < IOM_LOG_DEPTH; i++) begin
				shadow[i] <= next_shadow[i];
			end
			log_fill <= next_log_fill;
			prev_vec <= next_prev_vec;
			scan <= next_scan;
		end
	end

	// console-side read copy, refreshed slot by slot every five cycles
	iom_log_mem u_log (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.rd_idx(log_rd_idx),
		.rd_data(log_rd_data)
	);
	// reload request is deliberately ignored to protect parameters
	logic unused_reload;
	assign unused_reload = parameter_reload_request;

endmodule // iom_monitor

// ===== hdl/iom_pkg.sv
// package of constants and carrier types for the i/o monitor and alarm log
package iom_pkg;

	// =====================================================================
	// widths and counts
	localparam int IOM_SWITCHES = 8;
	localparam int IOM_VALVES = 8;
	localparam int IOM_SAFETY = 3;
	localparam int IOM_ENC_W = 16;
	localparam int IOM_ANA_W = 8;
	localparam int IOM_LOG_DEPTH = 5;
	localparam int IOM_IDX_W = 3;
	localparam int IOM_HOUR_W = 24;
	localparam int IOM_CNT_W = 8;
	localparam int IOM_TEMP_W = 8;

	// =====================================================================
	// timing
	localparam int IOM_CLK_HZ = 50000000;
	localparam int IOM_SILENCE_MS = 100;
	localparam int IOM_SILENCE_CYC = IOM_SILENCE_MS * (IOM_CLK_HZ / 1000);
	localparam int IOM_HOUR_S = 3600;
	localparam longint IOM_HOUR_CYC = longint'(IOM_HOUR_S) * IOM_CLK_HZ;

	// =====================================================================
	// alarm codes
	typedef enum logic [3:0] {
		IOM_ALM_NONE = 4'h0,
		IOM_ALM_PARAM_MEM = 4'h1,
		IOM_ALM_BUS_SILENCE = 4'h2,
		IOM_ALM_COIL_SHORT = 4'h3,
		IOM_ALM_HS_OPEN = 4'h4,
		IOM_ALM_GRP1 = 4'h5,
		IOM_ALM_GRP2 = 4'h6,
		IOM_ALM_GRP3 = 4'h7,
		IOM_ALM_HS_CLOSED = 4'h8
	} iom_alarm_t;
	localparam int IOM_NUM_ALARMS = 8;
	localparam logic [IOM_CNT_W-1:0] IOM_CNT_MAX = 8'hff;

	// target node codes from the console
	localparam logic [5:0] IOM_NODE_SUPERVISOR = 6'h01;
	localparam logic [5:0] IOM_NODE_TRACTION = 6'h02;
	localparam logic [5:0] IOM_NODE_PUMP = 6'h05;
	localparam logic [5:0] IOM_NODE_STEER = 6'h06;
	localparam logic [5:0] IOM_NODE_SELF = 6'h09;
	localparam logic [5:0] IOM_NODE_MAX = 6'h20;

	// =====================================================================
	// carriers
	typedef struct packed {
		logic [IOM_SWITCHES-1:0] switches;
		logic [IOM_VALVES-1:0] solenoid_valve_output;
		logic [IOM_SAFETY-1:0] safety_valves;
		logic [IOM_ENC_W-1:0] encoder;
		logic [IOM_ANA_W-1:0] analog_one;
		logic [IOM_ANA_W-1:0] analog_two;
		logic analog_select_a;
		logic analog_select_b;
	} iom_live_t;

	typedef struct packed {
		iom_alarm_t code;
		logic [IOM_CNT_W-1:0] count;
		logic [IOM_HOUR_W-1:0] hours;
		logic [IOM_TEMP_W-1:0] temp;
	} iom_entry_t;

	// field order follows the alarm codes: bit 7 is code 1, bit 0 code 8,
	// so the history logic can turn a bit index straight into a code
	typedef struct packed {
		logic param_memory_fault;
		logic bus_silence_fault;
		logic coil_short_alarm;
		logic high_side_stuck_open;
		logic group_one_transistor_short;
		logic group_two_transistor_short;
		logic group_three_transistor_short;
		logic high_side_stuck_closed;
	} iom_faults_t;

endpackage

// ===== hdl/iom_log_mem.sv
// five-entry alarm history store with registered read port
`timescale 1ns/1ps
module iom_log_mem
	import iom_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [IOM_IDX_W-1:0] wr_idx,
	input wire iom_entry_t wr_data,
	input wire logic [IOM_IDX_W-1:0] rd_idx,
	output iom_entry_t rd_data
);

	// =====================================================================
	// storage
	iom_entry_t mem [IOM_LOG_DEPTH]; // one word per history slot
	iom_entry_t next_rd_data; // read data before the output register

	// combinational read select; out-of-range index reads as empty
	always_comb begin
		next_rd_data = '0;
		if (32'(rd_idx) < IOM_LOG_DEPTH) begin
			next_rd_data = mem[rd_idx];
		end
	end

	// storage write; no reset so it can map onto plain ram
	always_ff @(posedge clk) begin
		if (ce && wr_en && 32'(wr_idx) < IOM_LOG_DEPTH) begin
			mem[wr_idx] <= wr_data;
		end
	end

	// registered read data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= '0;
		end else if (ce) begin
			rd_data <= next_rd_data;
		end
	end

endmodule // iom_log_mem

// ===== bench/iom_monitor_sva.sv
// assertion checker for the i/o monitor outputs
`timescale 1ns/1ps
module iom_monitor_sva
	import iom_pkg::*;
#(
	parameter longint SILENCE_CYC = IOM_SILENCE_CYC
)(
	input wire logic clk,
	input wire logic rst,
	input wire iom_live_t live_pins,
	input wire logic supervisor_msg,
	input wire logic coil_short_sense,
	input wire logic high_side_cmd,
	input wire logic high_side_sense,
	input wire logic [2:0] group_short_sense,
	input wire logic parameter_backup_request,
	input wire iom_live_t live,
	input wire iom_faults_t faults,
	input wire logic operation_inhibit,
	input wire logic load_defaults,
	input wire logic backup_ack
);
	// ==================================================================
	// helper counters
	logic [2:0] warm; // edges since reset; masks stale $past history
	longint quiet; // edges since the last supervisor frame
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			warm <= 3'h0;
			quiet <= 0;
		end else begin
			warm <= (warm == 3'h7) ? warm : warm + 3'h1;
			// capped so the counter cannot wrap on a long silence
			quiet <= supervisor_msg ? 0 : (quiet < SILENCE_CYC + 16) ?
				quiet + 1 : quiet;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst || warm < 3'h5);
	// ==================================================================
	// properties
	chk_live_delay: assert property (
		live == $past(live_pins, 3)) else $error("live image lags wrongly");
	chk_coil_flag: assert property (
		$rose(coil_short_sense) |-> ##3 faults.coil_short_alarm)
		else $error("coil short flag missing");
	chk_hs_open: assert property (
		$rose(high_side_cmd && !high_side_sense) |->
		##3 faults.high_side_stuck_open) else $error("stuck open missing");
	chk_hs_closed: assert property (
		$rose(!high_side_cmd && high_side_sense) |->
		##3 faults.high_side_stuck_closed) else $error("stuck closed missing");
	chk_grp_three: assert property (
		$rose(group_short_sense[2]) |->
		##3 faults.group_three_transistor_short) else $error("group flag");
	chk_ack_cause: assert property (
		backup_ack |-> $past(parameter_backup_request, 3) &&
		!$past(parameter_backup_request, 4)) else $error("stray backup ack");
	chk_backup_pulse: assert property (
		$rose(parameter_backup_request) |-> ##3 backup_ack ##1 !backup_ack)
		else $error("backup ack not one pulse");
	chk_inhibit_mem: assert property (
		operation_inhibit == faults.param_memory_fault)
		else $error("inhibit differs from memory fault");
	chk_defaults_once: assert property (
		load_defaults |=> !load_defaults && !operation_inhibit)
		else $error("defaults pulse wrong");
	chk_silence_set: assert property (
		quiet == SILENCE_CYC + 8 |-> faults.bus_silence_fault)
		else $error("bus silence not flagged");
	chk_silence_clear: assert property (
		quiet > 4 && quiet < SILENCE_CYC |-> !faults.bus_silence_fault)
		else $error("bus fault while frames arrive");
endmodule // iom_monitor_sva

bind iom_monitor iom_monitor_sva #(.SILENCE_CYC(SILENCE_CYC)) u_sva (
	.clk, .rst, .live_pins, .supervisor_msg, .coil_short_sense,
	.high_side_cmd, .high_side_sense, .group_short_sense,
	.parameter_backup_request, .live, .faults, .operation_inhibit,
	.load_defaults, .backup_ack
);

// ===== bench/iom_console.sv
// model of the console and supervisory node across the bus
`timescale 1ns/1ps
module iom_console
	import iom_pkg::*;
#(
	parameter logic [5:0] ATTACHED = IOM_NODE_SUPERVISOR
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic quiet,
	input wire logic slow,
	input wire logic backup_go,
	input wire logic misuse,
	input wire logic [5:0] target_node_code,
	output logic [5:0] node_selected,
	output logic supervisor_msg,
	output logic parameter_backup_request,
	output logic parameter_reload_request
);
	// ==================================================================
	// frame timing and request hold
	logic [3:0] tick = 4'h0; // edges since the last frame
	logic [2:0] hold = 3'h0; // edges the backup request still stands
	// frames every 4 edges, every 12 when slow; quiet means node gone
	always @(posedge clk) begin
		tick <= #1 (tick == (slow ? 4'hb : 4'h3)) ? 4'h0 : tick + 4'h1;
		supervisor_msg <= #1 !rst && !quiet && tick == 4'h0;
		hold <= #1 backup_go ? 3'h6 : (hold != 3'h0) ? hold - 3'h1 : 3'h0;
		parameter_backup_request <= #1 hold != 3'h0;
	end
	// reload stays low unless a scenario misuses it on purpose
	assign parameter_reload_request = misuse;
	// unlisted codes fall back to the node the console is wired to
	assign node_selected = target_node_code inside {IOM_NODE_SUPERVISOR,
		IOM_NODE_TRACTION, IOM_NODE_PUMP, IOM_NODE_STEER, IOM_NODE_SELF}
		? target_node_code : ATTACHED;
endmodule // iom_console

// ===== bench/iom_monitor_tb_top.sv
// self-checking bench for the i/o monitor and alarm log
`timescale 1ns/1ps
module iom_monitor_tb_top
	import iom_pkg::*;
();
	// ==================================================================
	// stimulus and observed signals
	localparam longint SIL = 20; // short silence timeout keeps runs brief
	logic clk = 1'b0;
	logic rst = 1'b1;
	iom_live_t live_pins = '0;
	logic coil = 1'b0, hs_cmd = 1'b0, hs_sense = 1'b0, mem = 1'b0;
	logic key_on = 1'b0, hour_mode = 1'b0, quiet = 1'b0, slow = 1'b0;
	logic bk_go = 1'b0, misuse = 1'b0, ce = 1'b1;
	logic [5:0] node_code = IOM_NODE_SELF; // console target selection
	logic [5:0] node_sel; // node the console model ends up on
	logic [2:0] grp = 3'h0;
	logic [7:0] temp = 8'h00;
	logic [2:0] rd_idx = 3'h0;
	logic msg, bk_req, rl_req, inhibit, load_def, bk_ack;
	iom_live_t live;
	iom_live_t last = '0; // last live image seen by the watcher
	iom_faults_t faults;
	logic [IOM_HOUR_W-1:0] hours;
	iom_entry_t rd;
	logic [IOM_IDX_W-1:0] fill;
	int err_count = 0, tests_run = 0, acks = 0, loads = 0;
	iom_live_t exp_live[$]; // expected live images, oldest first
	always #10 clk = ~clk;

	iom_monitor #(.SILENCE_CYC(SIL), .HOUR_CYC(10)) uut (.clk, .rst,
		.ce, .live_pins, .supervisor_msg(msg),
		.coil_short_sense(coil), .high_side_cmd(hs_cmd),
		.high_side_sense(hs_sense), .group_short_sense(grp),
		.mem_fault_sense(mem), .key_on, .hour_mode_key_on(hour_mode),
		.temperature(temp), .parameter_backup_request(bk_req),
		.parameter_reload_request(rl_req), .log_rd_idx(rd_idx), .live,
		.faults, .operation_inhibit(inhibit), .load_defaults(load_def),
		.backup_ack(bk_ack), .hour_meter(hours), .log_rd_data(rd),
		.log_fill(fill));
	iom_console u_con (.clk, .rst, .quiet, .slow, .backup_go(bk_go),
		.misuse, .target_node_code(node_code), .node_selected(node_sel),
		.supervisor_msg(msg), .parameter_backup_request(bk_req),
		.parameter_reload_request(rl_req));

	// ==================================================================
	// shared tasks
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// watcher: each new live image settles the oldest expectation
	// sampled on the falling edge, where registered outputs have settled
	always @(negedge clk) begin
		if (!rst && live !== last) begin
			check(live, exp_live.pop_front());
			last = live;
		end
		if (bk_ack === 1'b1) acks++;
		if (load_def === 1'b1) loads++;
	end

	// watchdog: the sequence needs about 420 edges, allow far more
	initial begin
		#(20 * 6000);
		err_count++;
		summarize();
	end

	// ==================================================================
	// main sequence
	initial begin
		iom_live_t v;
		logic [IOM_HOUR_W-1:0] h;
		iom_alarm_t order[5] = '{IOM_ALM_HS_CLOSED, IOM_ALM_HS_OPEN,
			IOM_ALM_GRP3, IOM_ALM_GRP2, IOM_ALM_GRP1};
		void'($urandom(71551));
		step(12);
		rst = 1'b0;
		step(2);
		// an unlisted code falls back to the attached node
		node_code = IOM_NODE_MAX;
		step(1);
		check(node_sel, IOM_NODE_SUPERVISOR);
		node_code = IOM_NODE_PUMP;
		step(1);
		check(node_sel, IOM_NODE_PUMP);
		// all-ones first, random pins, all-zeros last; reload misuse meanwhile
		for (int i = 0; i < 9; i++) begin
			v = (i == 0) ? '1 : (i == 8) ? '0 :
				iom_live_t'({$urandom, $urandom});
			exp_live.push_back(v);
			live_pins = v;
			misuse = i[0];
			step(5);
		end
		check(exp_live.size(), 0);
		bk_go = 1'b1;
		step(1);
		bk_go = 1'b0;
		step(12);
		check(acks, 1);
		check({faults, inhibit, load_def}, 0);
		// faults in turn fill the history past its depth
		temp = 8'h5a;
		coil = 1'b1;
		step(4);
		check(faults.coil_short_alarm, 1);
		coil = 1'b0;
		step(9);
		check({fill, rd.code, rd.count, rd.temp},
			{3'h1, IOM_ALM_COIL_SHORT, 8'h01, 8'h5a});
		for (int g = 0; g < 3; g++) begin
			grp[g] = 1'b1;
			step(4);
			check(faults[3-g], 1);
		end
		hs_cmd = 1'b1;
		step(4);
		check(faults.high_side_stuck_open, 1);
		hs_cmd = 1'b0;
		hs_sense = 1'b1;
		step(4);
		check(faults.high_side_stuck_closed, 1);
		for (int k = 0; k < 5; k++) begin
			rd_idx = k[2:0];
			step(9);
			check({fill, rd.code}, {3'h5, order[k]});
		end
		// key cycle clears hardware faults; a repeat bumps its count
		slow = 1'b1;
		grp = 3'h0;
		hs_sense = 1'b0;
		rd_idx = 3'h0;
		step(4);
		key_on = 1'b1;
		step(6);
		check(faults, 0);
		hs_sense = 1'b1;
		step(13);
		check({fill, rd.code, rd.count},
			{3'h5, IOM_ALM_HS_CLOSED, 8'h02});
		hs_sense = 1'b0;
		slow = 1'b0;
		// supervisor silence raises and drops the bus fault
		quiet = 1'b1;
		step(SIL + 12);
		check(faults.bus_silence_fault, 1);
		quiet = 1'b0;
		step(8);
		check(faults.bus_silence_fault, 0);
		// memory fault survives a key cycle while present
		key_on = 1'b0;
		mem = 1'b1;
		step(4);
		check({faults.param_memory_fault, inhibit}, 2'h3);
		key_on = 1'b1;
		step(6);
		key_on = 1'b0;
		mem = 1'b0;
		step(6);
		check({inhibit, loads[7:0]}, {1'b1, 8'h00});
		key_on = 1'b1;
		step(6);
		check({inhibit, loads[7:0]}, {1'b0, 8'h01});
		// hour meter: idle outputs hold it in running mode only
		h = hours;
		step(50);
		check(hours, h);
		hour_mode = 1'b1;
		h = hours;
		step(100);
		check((hours - h) inside {24'd9, 24'd10, 24'd11}, 1);
		// clock enable low freezes the hour meter with everything else
		ce = 1'b0;
		h = hours;
		step(30);
		check(hours, h);
		ce = 1'b1;
		summarize();
	end
endmodule // iom_monitor_tb_top
